// ===== src/pwm_db_pkg.sv
// constants and register layout for the pwm dead-band and auto-shutdown block
package pwm_db_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  OFS_CFG        = 8'h00;  // pwm_deadband_restart_config
    localparam logic [7:0]  OFS_SDC        = 8'h04;  // pwm_shutdown_control
    localparam logic [7:0]  OFS_MCTL       = 8'h08;  // module_control_reg
    localparam logic [7:0]  OFS_PINDIR     = 8'h0c;  // pin drive enables
    localparam logic [7:0]  OFS_STAT       = 8'h10;  // live state, read only

    // ------------------------------------------------------------------
    // reset values and write masks
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_REG8       = 8'h00;
    localparam logic [3:0]  RST_PINDIR     = 4'h0;
    localparam logic [31:0] RST_RDATA      = 32'h0000_0000;
    localparam logic [7:0]  CFG_MASK_FULL  = 8'hff;
    localparam logic [7:0]  CFG_MASK_SMALL = 8'h80;
    localparam logic [7:0]  SDC_MASK_FULL  = 8'hff;
    localparam logic [7:0]  SDC_MASK_SMALL = 8'hfc;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          CFG_RESTART    = 7;      // auto_restart_enable
    localparam int          DBC_W          = 7;      // dead_band_count in [6:0]
    localparam int          SDC_STATUS     = 7;      // shutdown_status
    localparam int          SDC_SEL_HI     = 6;      // shutdown_source_select [6:4]
    localparam int          SDC_SEL_LO     = 4;
    localparam int          SDC_AC_HI      = 3;      // pair_ac_shutdown_level [3:2]
    localparam int          SDC_AC_LO      = 2;
    localparam int          SDC_BD_HI      = 1;      // pair_bd_shutdown_level [1:0]
    localparam int          SDC_BD_LO      = 0;
    localparam int          MCTL_CFG_HI    = 7;      // output_config_select [7:6]
    localparam int          MCTL_CFG_LO    = 6;
    localparam int          MCTL_MODE_HI   = 3;      // module_mode_select [3:2]
    localparam int          MCTL_MODE_LO   = 2;
    localparam int          MCTL_POL_AC    = 1;      // output_polarity_select [1:0]
    localparam int          MCTL_POL_BD    = 0;
    localparam logic [1:0]  MODE_ENH_PWM   = 2'b11;  // module_mode_select[3:2]

    // ------------------------------------------------------------------
    // output configurations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OCFG_SINGLE  = 2'b00,
        OCFG_HALF    = 2'b10,
        OCFG_FULL_FW = 2'b01,
        OCFG_FULL_RV = 2'b11
    } out_cfg_e;

endpackage

// ===== src/pwm_deadband_autoshutdown.sv
// pwm output conditioning: dead-band, auto-shutdown, polarity, apb registers
//
// How it works
// R1: half-bridge delays only inactive-to-active edges; falling edges pass at once
// R2: seven-bit dead-band count delays each activation by that many clock cycles
// R3: auto-shutdown works on the active pins in any enhanced pwm mode
// R4: sources are comparator 1, comparator 2 and a low fault pin
// R5: three-bit select picks the source combination, 000 disables
// R6: shutdown forces each pin pair independently to its shutdown level
// R7: pair A/C level: 1x tri-state, 01 high, 00 low
// R8: pair B/D level: 1x tri-state, 01 high, 00 low
// R9: hardware sets shutdown_status on an event; outputs held while set
// R10: status set at period start keeps outputs shut down all period
// R11: after status clears, outputs resume only at next period start
// R12: with auto restart, status clears itself once the cause is gone
// R13: without auto restart, status stays set until firmware clears it
// R14: firmware writes to status are ignored while a cause is active
// R15: comparator sources act as levels; status cannot clear while present
// R16: firmware writing 1 to status forces shutdown
// R17: two polarity bits set active-high or active-low per pin pair
// R18: firmware picks polarity before enabling pin drivers
// R19: firmware waits one full pwm period before enabling pin drivers
// R20: firmware follows the documented setup order
// R21: small package: dead-band count and B/D level bits read zero
// R22: half-bridge: A carries pwm, B its complement; long delay keeps inactive
// R23: reset returns all registers to zero; the fault synchroniser flt_s resets to ones instead
// R24: each pair has its own dead-band down-counter, reloaded per activation
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps

module pwm_deadband_autoshutdown
    import pwm_db_pkg::*;
#(
    parameter bit SMALL_PKG = 1'b0
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // pwm core, same clock
    input  wire logic              pwm_raw_i,
    input  wire logic              period_start_i,
    // shutdown sources, asynchronous
    input  wire logic              cmp1_i,
    input  wire logic              cmp2_i,
    input  wire logic              fault_input_n_i,
    // bridge pins
    output logic                   out_a_o,
    output logic                   out_a_oe_o,
    output logic                   out_b_o,
    output logic                   out_b_oe_o,
    output logic                   out_c_o,
    output logic                   out_c_oe_o,
    output logic                   out_d_o,
    output logic                   out_d_oe_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]       cfg;
        logic [7:0]       sdc;
        logic [7:0]       mctl;
        logic [3:0]       pindir;
        logic [1:0]       cmp1_s;
        logic [1:0]       cmp2_s;
        logic [1:0]       flt_s;
        logic             pwm_d;
        logic [DBC_W-1:0] cnt_ac;
        logic [DBC_W-1:0] cnt_bd;
        logic             forced;
        logic [3:0]       pin;
        logic [3:0]       oe;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } state_s;

    localparam state_s STATE_RST = '{
        cfg: RST_REG8, sdc: RST_REG8, mctl: RST_REG8, pindir: RST_PINDIR,
        cmp1_s: 2'h0, cmp2_s: 2'h0, flt_s: 2'h3, pwm_d: 1'b0,
        cnt_ac: '0, cnt_bd: '0, forced: 1'b0, pin: 4'h0, oe: 4'h0,
        pready: 1'b0, pslverr: 1'b0, prdata: RST_RDATA};

    localparam logic [7:0] CFG_MASK = SMALL_PKG ? CFG_MASK_SMALL : CFG_MASK_FULL;
    localparam logic [7:0] SDC_MASK = SMALL_PKG ? SDC_MASK_SMALL : SDC_MASK_FULL;

    state_s r;
    state_s n;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic sd_cause(input logic [2:0] sel, input logic c1,
                                      input logic c2, input logic flt_n);
        sd_cause = (sel[0] & c1) | (sel[1] & c2) | (sel[2] & ~flt_n);
    endfunction

    // returns {pin level, output enable}
    function automatic logic [1:0] drive(input logic en, input logic frc,
                                         input logic [1:0] lvl, input logic act,
                                         input logic pol_low);
        if (!en) begin
            drive = 2'b00;
        end else if (frc) begin
            drive = lvl[1] ? 2'b00 : {lvl[0], 1'b1};
        end else begin
            drive = {act ^ pol_low, 1'b1};
        end
    endfunction

    function automatic logic [DBC_W-1:0] db_step(input logic load,
                                                 input logic [DBC_W-1:0] dbc,
                                                 input logic [DBC_W-1:0] cnt);
        if (load) begin
            db_step = dbc;
        end else if (cnt != '0) begin
            db_step = cnt - 1'b1;
        end else begin
            db_step = cnt;
        end
    endfunction

    // ------------------------------------------------------------------
    // combinational view
    // ------------------------------------------------------------------
    logic             enh;
    logic             half;
    logic             cause;
    logic             setup;
    logic             wr;
    logic             wr_sd;
    logic             mapped;
    logic             act_a;
    logic             act_b;
    logic             act_c;
    logic             act_d;
    logic             rise_a;
    logic             rise_b;
    logic [DBC_W-1:0] dbc;
    out_cfg_e         ocfg;
    logic [7:0]       rd_val;

    assign enh   = r.mctl[MCTL_MODE_HI:MCTL_MODE_LO] == MODE_ENH_PWM;
    assign ocfg  = out_cfg_e'(r.mctl[MCTL_CFG_HI:MCTL_CFG_LO]);
    assign half  = enh && (ocfg == OCFG_HALF);
    assign dbc   = r.cfg[DBC_W-1:0];
    assign cause = enh && sd_cause(r.sdc[SDC_SEL_HI:SDC_SEL_LO], r.cmp1_s[1],
                                   r.cmp2_s[1], r.flt_s[1]);         // [R3] [R4] [R5]
    assign setup = psel_i && !penable_i;
    assign wr    = psel_i && penable_i && r.pready && pwrite_i && !r.pslverr;
    assign wr_sd = wr && (paddr_i == OFS_SDC);
    assign mapped = (paddr_i == OFS_CFG) || (paddr_i == OFS_SDC) || (paddr_i == OFS_MCTL)
                 || (paddr_i == OFS_PINDIR) || (paddr_i == OFS_STAT);

    always_comb begin
        act_a = 1'b0;
        act_b = 1'b0;
        act_c = 1'b0;
        act_d = 1'b0;
        case (ocfg)
            OCFG_SINGLE: begin
                act_a = pwm_raw_i;
            end
            OCFG_HALF: begin
                act_a = pwm_raw_i;                                    // [R22]
                act_b = !pwm_raw_i;
            end
            OCFG_FULL_FW: begin
                act_a = 1'b1;
                act_d = pwm_raw_i;
            end
            OCFG_FULL_RV: begin
                act_c = 1'b1;
                act_b = pwm_raw_i;
            end
            default: begin
                act_a = 1'b0;
            end
        endcase
    end

    assign rise_a = half && pwm_raw_i && !r.pwm_d;
    assign rise_b = half && !pwm_raw_i && r.pwm_d;

    always_comb begin
        case (paddr_i)
            OFS_CFG:    rd_val = r.cfg;
            OFS_SDC:    rd_val = r.sdc;
            OFS_MCTL:   rd_val = r.mctl;
            OFS_PINDIR: rd_val = {4'h0, r.pindir};
            OFS_STAT:   rd_val = {6'h00, r.forced, cause};
            default:    rd_val = RST_REG8;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic [1:0] dr_a;
    logic [1:0] dr_b;
    logic [1:0] dr_c;
    logic [1:0] dr_d;
    logic       pa;
    logic       pb;

    always_comb begin
        n = r;
        // synchronisers
        n.cmp1_s = {r.cmp1_s[0], cmp1_i};
        n.cmp2_s = {r.cmp2_s[0], cmp2_i};
        n.flt_s  = {r.flt_s[0], fault_input_n_i};
        // apb access
        n.pready  = setup;
        n.pslverr = setup && !mapped;
        if (setup && !pwrite_i) begin
            n.prdata = {24'h000000, rd_val};
        end
        if (wr) begin
            case (paddr_i)
                OFS_CFG:    n.cfg = pwdata_i[7:0] & CFG_MASK;                    // [R21]
                OFS_SDC:    n.sdc[SDC_SEL_HI:0] = pwdata_i[SDC_SEL_HI:0] & SDC_MASK[SDC_SEL_HI:0];
                OFS_MCTL:   n.mctl = pwdata_i[7:0];                              // [R17]
                OFS_PINDIR: n.pindir = pwdata_i[3:0];                    // [R19]
                default:    n.cfg = r.cfg;
            endcase
        end
        // shutdown status: a live cause beats any write
        if (cause) begin
            n.sdc[SDC_STATUS] = 1'b1;                                 // [R9] [R14] [R15]
        end else if (wr_sd) begin
            n.sdc[SDC_STATUS] = pwdata_i[SDC_STATUS];                 // [R13] [R16]
        end else if (r.cfg[CFG_RESTART]) begin
            n.sdc[SDC_STATUS] = 1'b0;                                 // [R12]
        end
        // hold outputs until a period starts with status clear
        n.forced = period_start_i ? n.sdc[SDC_STATUS]
                                  : (r.forced | n.sdc[SDC_STATUS]);  // [R6] [R10] [R11]
        // dead-band counters, one per pair
        n.pwm_d  = pwm_raw_i;
        n.cnt_ac = db_step(rise_a, dbc, r.cnt_ac);                    // [R24] [R2]
        n.cnt_bd = db_step(rise_b, dbc, r.cnt_bd);                    // [R24]
        // pin drive; dead-band gates only the activation
        pa   = act_a && (!half || n.cnt_ac == '0);                    // [R1] [R22]
        pb   = act_b && (!half || n.cnt_bd == '0);                    // [R1]
        dr_a = drive(enh && r.pindir[0], n.forced, r.sdc[SDC_AC_HI:SDC_AC_LO], pa,
                     r.mctl[MCTL_POL_AC]);                            // [R7] [R17]
        dr_c = drive(enh && r.pindir[2], n.forced, r.sdc[SDC_AC_HI:SDC_AC_LO], act_c,
                     r.mctl[MCTL_POL_AC]);                            // [R7]
        dr_b = drive(enh && r.pindir[1], n.forced, r.sdc[SDC_BD_HI:SDC_BD_LO], pb,
                     r.mctl[MCTL_POL_BD]);                            // [R8] [R17]
        dr_d = drive(enh && r.pindir[3], n.forced, r.sdc[SDC_BD_HI:SDC_BD_LO], act_d,
                     r.mctl[MCTL_POL_BD]);                            // [R8]
        n.pin = {dr_d[1], dr_c[1], dr_b[1], dr_a[1]};
        n.oe  = {dr_d[0], dr_c[0], dr_b[0], dr_a[0]};
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= STATE_RST;                                           // [R23]
        end else begin
            r <= n;
        end
    end

    assign prdata_o   = r.prdata;
    assign pready_o   = r.pready;
    assign pslverr_o  = r.pslverr;
    assign out_a_o    = r.pin[0];
    assign out_b_o    = r.pin[1];
    assign out_c_o    = r.pin[2];
    assign out_d_o    = r.pin[3];
    assign out_a_oe_o = r.oe[0];
    assign out_b_oe_o = r.oe[1];
    assign out_c_oe_o = r.oe[2];
    assign out_d_oe_o = r.oe[3];

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_rise_a_clean;
        rise_a && !n.forced && r.pindir[0] && (dbc != '0);
    endsequence

    sequence s_fault_seen;
        enh && r.sdc[SDC_SEL_HI] && !r.flt_s[1];
    endsequence

    property p_db_load;                                               // [R24]
        s_rise_a_clean |=> (r.cnt_ac == $past(dbc)) && (r.pin[0] == r.mctl[MCTL_POL_AC]);
    endproperty
    a_db_load: assert property (p_db_load)                            // [R2]
        else $error("dead-band counter not loaded or pin A went active early");

    property p_fall_undelayed;
        half && !pwm_raw_i && r.pwm_d && !n.forced && r.pindir[0]
            |=> r.oe[0] && (r.pin[0] == r.mctl[MCTL_POL_AC]);
    endproperty
    a_fall_undelayed: assert property (p_fall_undelayed)              // [R1]
        else $error("pin A deactivation was delayed");

    property p_fault_sets;
        s_fault_seen |=> r.sdc[SDC_STATUS] && r.forced;
    endproperty
    a_fault_sets: assert property (p_fault_sets)                      // [R9]
        else $error("fault did not set shutdown status");

    property p_disabled_quiet;
        enh && (r.sdc[SDC_SEL_HI:SDC_SEL_LO] == 3'b000) && !r.sdc[SDC_STATUS] && !wr_sd
            |=> !r.sdc[SDC_STATUS];
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)              // [R5]
        else $error("shutdown status set with sources disabled");

    property p_hold_period;
        r.forced && !period_start_i |=> r.forced;
    endproperty
    a_hold_period: assert property (p_hold_period)                    // [R10]
        else $error("shutdown hold released inside a period");

    property p_resume_at_start;
        r.forced && period_start_i && !n.sdc[SDC_STATUS] |=> !r.forced;
    endproperty
    a_resume_at_start: assert property (p_resume_at_start)            // [R11]
        else $error("outputs did not resume at period start");

    property p_auto_restart;
        r.cfg[CFG_RESTART] && r.sdc[SDC_STATUS] && !cause && !wr_sd |=> !r.sdc[SDC_STATUS];
    endproperty
    a_auto_restart: assert property (p_auto_restart)                  // [R12]
        else $error("auto restart did not clear status");

    property p_manual_hold;
        !r.cfg[CFG_RESTART] && r.sdc[SDC_STATUS] && !wr_sd |=> r.sdc[SDC_STATUS] [*1];
    endproperty
    a_manual_hold: assert property (p_manual_hold)                    // [R13]
        else $error("status cleared without firmware");

    property p_write_blocked;
        cause && wr_sd && !pwdata_i[SDC_STATUS] |=> r.sdc[SDC_STATUS];
    endproperty
    a_write_blocked: assert property (p_write_blocked)                // [R14]
        else $error("status cleared while cause active");

    property p_force_write;
        wr_sd && pwdata_i[SDC_STATUS] |=> r.sdc[SDC_STATUS] && r.forced;
    endproperty
    a_force_write: assert property (p_force_write)                    // [R16]
        else $error("write of one did not force shutdown");

    property p_tristate_ac;
        n.forced && r.sdc[SDC_AC_HI] |=> !r.oe[0] && !r.oe[2];
    endproperty
    a_tristate_ac: assert property (p_tristate_ac)                    // [R7]
        else $error("pair A/C not tri-stated in shutdown");

    property p_small_zero;
        SMALL_PKG |-> (r.cfg[DBC_W-1:0] == '0) && (r.sdc[SDC_BD_HI:SDC_BD_LO] == 2'b00);
    endproperty
    a_small_zero: assert property (p_small_zero)                      // [R21]
        else $error("unimplemented bits not zero");

endmodule // pwm_deadband_autoshutdown

// ===== verification/bridge_model.sv
// bridge driver model: resolves pin levels and flags shoot-through
`timescale 1ns/1ps

module bridge_model (
    // clock and watch window
    input  wire logic       clk_i,
    input  wire logic       watch_i,
    // pins from the block
    input  wire logic [3:0] pin_i,
    input  wire logic [3:0] oe_i,
    // resolved lines and hazard flag
    output logic      [3:0] line_o,
    output logic            shoot_o
);
    // released pins are held off by external pull-downs
    assign line_o = pin_i & oe_i;

    initial shoot_o = 1'b0;

    // high and low switch of one leg on together
    always @(posedge clk_i) begin
        if (watch_i && line_o[0] && line_o[1]) begin
            shoot_o <= 1'b1;
        end
    end
endmodule // bridge_model

// ===== verification/pwm_deadband_autoshutdown_tb.sv
// self-checking bench for the dead-band and auto-shutdown block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; $display("BAD %s exp %0h got %0h", nm, e, s); end end

module pwm_deadband_autoshutdown_tb
    import pwm_db_pkg::*;
;
    logic        clk_i, arst_n_i, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat, prdata_s;
    logic        pwm, pstart, cmp1, cmp2, fault_n, watch, shoot, hit;
    logic [3:0]  pin, oe, line, lv;
    int          mismatches, checked, nb, k, k2;

    pwm_deadband_autoshutdown u_pwm_deadband_autoshutdown (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .pwm_raw_i(pwm), .period_start_i(pstart),
        .cmp1_i(cmp1), .cmp2_i(cmp2), .fault_input_n_i(fault_n),
        .out_a_o(pin[0]), .out_a_oe_o(oe[0]), .out_b_o(pin[1]), .out_b_oe_o(oe[1]),
        .out_c_o(pin[2]), .out_c_oe_o(oe[2]), .out_d_o(pin[3]), .out_d_oe_o(oe[3]));

    // small package variant on the same bus; only its read data is watched
    pwm_deadband_autoshutdown #(.SMALL_PKG(1'b1)) u_pwm_deadband_autoshutdown_small (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_s),
        .pready_o(), .pslverr_o(), .pwm_raw_i(pwm), .period_start_i(pstart),
        .cmp1_i(cmp1), .cmp2_i(cmp2), .fault_input_n_i(fault_n),
        .out_a_o(), .out_a_oe_o(), .out_b_o(), .out_b_oe_o(),
        .out_c_o(), .out_c_oe_o(), .out_d_o(), .out_d_oe_o());

    bridge_model u_bridge_model (.clk_i(clk_i), .watch_i(watch), .pin_i(pin), .oe_i(oe),
        .line_o(line), .shoot_o(shoot));

    // ------------------------------------------------------------------
    // bus, pin and timing helpers
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk_i);
        penable <= 1'b1;
        do begin @(posedge clk_i); end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK("rdata", {24'h0, e}, rdat)
    endtask

    task automatic pc(input int p, input logic [1:0] e);
        `CHK("pin", e, {oe[p], pin[p]})
    endtask

    task automatic wait_pin(input int p, input logic v, output int n);
        n = 0;
        while (pin[p] !== v && n < 200) begin @(posedge clk_i); #1; n++; end
    endtask

    task automatic pulse_ps();
        @(posedge clk_i);
        pstart <= 1'b1;
        @(posedge clk_i);
        pstart <= 1'b0;
        #1;
    endtask

    function automatic logic [1:0] sdlvl(input logic [1:0] l);
        return l[1] ? 2'b00 : {1'b1, l[0]};
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        #300000;
        mismatches++;
        conclude();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h77e74cc1));
        {arst_n_i, psel, penable, pwrite, paddr, pwdata, pwm, pstart} = '0;
        {cmp1, cmp2, watch, mismatches, checked} = '0;
        fault_n = 1'b1;
        repeat (16) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rd(OFS_CFG, 8'h00);
        rd(OFS_SDC, 8'h00);
        rd(OFS_MCTL, 8'h00);
        rd(8'h14, 8'h00);
        `CHK("pslverr", 1'b1, rerr)
        nb = $urandom % 256;
        apb(1'b1, OFS_CFG, nb[7:0]);
        rd(OFS_CFG, nb[7:0]);
        `CHK("small_cfg", {24'h0, nb[7], 7'h00}, prdata_s)
        // polarity and mode first, one full period, then drivers on
        apb(1'b1, OFS_CFG, 8'h00);
        apb(1'b1, OFS_MCTL, 8'h8c);
        pulse_ps();
        pulse_ps();
        apb(1'b1, OFS_PINDIR, 8'h0f);
        watch <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            nb = (i == 0) ? 0 : (i == 1) ? 127 : 1 + $urandom % 30;
            apb(1'b1, OFS_CFG, nb[7:0]);
            repeat (nb + 3) @(posedge clk_i);
            pwm <= 1'b1;
            wait_pin(1, 1'b0, k);
            `CHK("b_off", 1, k)
            wait_pin(0, 1'b1, k2);
            `CHK("a_on", nb + 1, k + k2)
            @(posedge clk_i);
            pwm <= 1'b0;
            wait_pin(0, 1'b0, k);
            `CHK("a_off", 1, k)
            wait_pin(1, 1'b1, k2);
            `CHK("b_on", nb + 1, k + k2)
        end
        apb(1'b1, OFS_CFG, 8'd20);
        pwm <= 1'b1;
        repeat (10) @(posedge clk_i);
        #1 pc(0, 2'b10);
        @(posedge clk_i);
        pwm <= 1'b0;
        watch <= 1'b0;
        `CHK("shoot", 1'b0, shoot)
        apb(1'b1, OFS_CFG, 8'h00);
        apb(1'b1, OFS_MCTL, 8'h8f);
        repeat (24) @(posedge clk_i);
        #1 pc(0, 2'b11);
        pc(1, 2'b10);
        apb(1'b1, OFS_MCTL, 8'h8c);
        for (int s = 0; s < 8; s++) begin
            for (int src = 0; src < 3; src++) begin
                lv = $urandom;
                hit = s[src];
                apb(1'b1, OFS_SDC, {1'b0, s[2:0], lv});
                cmp1 <= (src == 0);
                cmp2 <= (src == 1);
                fault_n <= (src != 2);
                repeat (4) @(posedge clk_i);
                #1 pc(0, hit ? sdlvl(lv[3:2]) : 2'b10);
                pc(1, hit ? sdlvl(lv[1:0]) : 2'b11);
                pc(2, hit ? sdlvl(lv[3:2]) : 2'b10);
                pc(3, hit ? sdlvl(lv[1:0]) : 2'b10);
                apb(1'b1, OFS_SDC, {1'b0, s[2:0], lv});
                rd(OFS_SDC, {hit, s[2:0], lv});
                {cmp1, cmp2, fault_n} <= 3'b001;
                repeat (4) @(posedge clk_i);
                pulse_ps();
                pc(0, hit ? sdlvl(lv[3:2]) : 2'b10);
                rd(OFS_SDC, {hit, s[2:0], lv});
                apb(1'b1, OFS_SDC, {1'b0, s[2:0], lv});
                @(posedge clk_i);
                #1 pc(0, hit ? sdlvl(lv[3:2]) : 2'b10);
                pulse_ps();
                pc(0, 2'b10);
            end
        end
        apb(1'b1, OFS_SDC, 8'h88);
        @(posedge clk_i);
        #1 pc(0, 2'b00);
        pc(1, 2'b10);
        apb(1'b1, OFS_SDC, 8'h00);
        pulse_ps();
        apb(1'b1, OFS_CFG, 8'h80);
        apb(1'b1, OFS_SDC, 8'h15);
        cmp1 <= 1'b1;
        repeat (12) @(posedge clk_i);
        rd(OFS_SDC, 8'h95);
        `CHK("small_sdc", 32'h94, prdata_s)
        cmp1 <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(OFS_SDC, 8'h15);
        pulse_ps();
        pc(0, 2'b10);
        // full-bridge, single and disabled configurations
        apb(1'b1, OFS_MCTL, 8'h4c);
        pwm <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 pc(0, 2'b11);
        pc(3, 2'b11);
        pc(1, 2'b10);
        apb(1'b1, OFS_SDC, 8'h94);
        @(posedge clk_i);
        #1 pc(3, 2'b10);
        pulse_ps();
        pc(3, 2'b11);
        apb(1'b1, OFS_MCTL, 8'hcc);
        repeat (2) @(posedge clk_i);
        #1 pc(2, 2'b11);
        pc(1, 2'b11);
        apb(1'b1, OFS_MCTL, 8'h0c);
        repeat (2) @(posedge clk_i);
        #1 pc(0, 2'b11);
        pc(2, 2'b10);
        apb(1'b1, OFS_MCTL, 8'h00);
        repeat (2) @(posedge clk_i);
        #1 pc(0, 2'b00);
        conclude();
    end
endmodule // pwm_deadband_autoshutdown_tb
